// ===== dv/pcg_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_ovf_checker (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic [`PCG_AW-1:0] paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`PCG_DW-1:0] pwdata,
    input wire logic [`PCG_DW-1:0] prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               irq_wired,
    input wire logic               msi_req,
    input wire logic [`PCG_DW-1:0] msi_data,
    input wire logic               msi_ack
);
    logic [2:0] ctl_ff;
    wire logic  rd = psel && penable && pready && !pwrite;
    // shadow of the group enables, tracked from completed writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_ff <= 3'h4;
        else if (psel && penable && pready && pwrite && paddr == 12'h038)
            ctl_ff <= pwdata[2:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    cfg_read_a: assert property (rd && paddr == 12'h044 |-> prdata == 32'h0000_0303)
        else $error("capability word wrong");
    capr_read_a: assert property (rd && paddr == 12'h03c |-> prdata == 32'h0000_0000)
        else $error("capture trigger reads nonzero");
    irq_pulse_a: assert property (irq_wired |=> !irq_wired)
        else $error("wired interrupt wider than one cycle");
    irq_gate_a: assert property (irq_wired |-> ctl_ff[0] && ctl_ff[2])
        else $error("wired interrupt while disabled");
    msi_gate_a: assert property ($rose(msi_req) |-> ctl_ff[0] && ctl_ff[1])
        else $error("message request while disabled");
    msi_hold_a: assert property (msi_req && !msi_ack |=> msi_req && $stable(msi_data))
        else $error("message request dropped before ack");
    err_map_a: assert property (pready |-> pslverr == (paddr > 12'h044))
        else $error("error response on wrong address");
    rd_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access phase");
    rst_quiet_a: assert property ($rose(presetn) |-> !irq_wired && !msi_req)
        else $error("interrupt right after reset");
    cover property (irq_wired);
    cover property (msi_req && msi_ack);
    cover property (pready && pslverr);
endmodule
bind pcg_counter_group pcg_ovf_checker u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_wired(irq_wired), .msi_req(msi_req),
    .msi_data(msi_data), .msi_ack(msi_ack)
);
`default_nettype wire

// ===== dv/pcg_irq_sink.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_irq_sink (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        msi_req,
    output var  logic        msi_ack,
    output var  logic [31:0] acks
);
    logic [2:0] wait_ff;
    // accepts the message write; no coherency attribute is looked at
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msi_ack <= 1'b0;
            wait_ff <= 3'h0;
            acks    <= 32'h0000_0000;
        end
        else if (msi_ack)
        begin
            msi_ack <= 1'b0;
            wait_ff <= 3'h0;
        end
        else if (msi_req && (!slow || wait_ff == 3'h5))
        begin
            msi_ack <= 1'b1;
            acks    <= acks + 1;
        end
        else if (msi_req)
            wait_ff <= wait_ff + 3'h1;
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, ev_on;
    logic        evt_trans, evt_tlb_miss, ext_capture, irq_wired, msi_req, msi_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, msi_data, acks, mrd, mctl, mmsi;
    logic [31:0] seed = 32'h0000_9333;
    logic [31:0] mc [4], ms [4], me [4];
    logic [3:0]  mo;
    logic [2:0]  mx;
    integer      fails, total_checks, xirq, xmsi, i, r;
    integer      nirq = 0;
    pcg_counter_group dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_trans(evt_trans),
        .evt_tlb_miss(evt_tlb_miss), .ext_capture(ext_capture), .irq_wired(irq_wired),
        .msi_req(msi_req), .msi_data(msi_data), .msi_ack(msi_ack));
    pcg_irq_sink u_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .msi_req(msi_req),
        .msi_ack(msi_ack), .acks(acks));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [31:0] rdv(input logic [11:0] a);
        if (a < 12'h010) return mc[a[3:2]];
        if (a < 12'h020) return ms[a[3:2]];
        if (a < 12'h030) return me[a[3:2]];
        case (a)
            12'h030, 12'h034: return {28'h000_0000, mo};
            12'h038: return mctl;
            12'h040: return mmsi;
            12'h044: return 32'h0000_0303;
            default: return 32'h0000_0000;
        endcase
    endfunction
    // reference model of the group, updated at the same edges as the design
    always @(posedge pclk or negedge presetn)
    begin : mdl
        logic       cap, ovi;
        logic [3:0] ovb;
        if (!presetn)
        begin
            for (int k = 0; k < 4; k++) {mc[k], ms[k], me[k]} = 96'h0;
            mo = 4'h0;
            mx = 3'h0;
            mctl = 32'h0000_0004;
            mmsi = 32'h0000_0000;
        end
        else
        begin
            if (psel && !penable) mrd = rdv(paddr);
            {cap, ovi, ovb} = 6'h00;
            // external trigger: two sync stages, then a rising-edge detect
            cap = mx[1] & ~mx[2];
            mx = {mx[1], mx[0], ext_capture};
            for (int k = 0; k < 4; k++)
                if (me[k][15:0] == 16'h0000 || (me[k][15:0] == 16'h0001 && evt_trans) ||
                    (me[k][15:0] == 16'h0002 && evt_tlb_miss))
                begin
                    mc[k] = mc[k] + 1;
                    if (mc[k] == 32'h0000_0000) {ovb[k], cap, ovi} = {1'b1, cap | me[k][30], ovi | me[k][31]};
                end
            mo = mo | ovb;
            if (ovi && mctl[0] && mctl[2]) xirq++;
            if (ovi && mctl[0] && mctl[1]) xmsi++;
            if (psel && penable && pwrite)
            begin
                if (paddr < 12'h010) mc[paddr[3:2]] = pwdata;
                else if (paddr >= 12'h020 && paddr < 12'h030) me[paddr[3:2]] = pwdata;
                else if (paddr == 12'h030) mo = mo | pwdata[3:0];
                else if (paddr == 12'h034) mo = (mo & ~pwdata[3:0]) | ovb;
                else if (paddr == 12'h038) mctl = pwdata;
                else if (paddr == 12'h03c) cap = cap | pwdata[0];
                else if (paddr == 12'h040) mmsi = pwdata;
            end
            if (cap) for (int k = 0; k < 4; k++) ms[k] = mc[k];
        end
    end
    always @(posedge pclk)
    begin
        seed <= lfsr(seed);
        evt_trans <= ev_on & seed[0];
        evt_tlb_miss <= ev_on & seed[5];
        if (irq_wired === 1'b1) nirq = nirq + 1;
        if (msi_req === 1'b1 && msi_ack === 1'b1) `CHK("msi_data", msi_data, mmsi)
    end
    task end_sim;
        begin
            if (fails == 0 && total_checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
            if (n >= 20) begin fails++; end_sim; end
            if (!w) `CHK("prdata", prdata, mrd)
            `CHK("pslverr", pslverr, a > 12'h044)
            {psel, penable} <= 2'b00;
        end
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_capture, slow, ev_on} = 0;
        {evt_trans, evt_tlb_miss, fails, total_checks, xirq, xmsi} = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 19; i++) apb(1'b0, i * 4, 0);
        apb(1'b1, 12'h020, 32'hc000_0001);
        apb(1'b1, 12'h024, 32'h0000_0002);
        apb(1'b1, 12'h028, 32'h0000_0080);
        apb(1'b1, 12'h02c, 32'h4000_0000);
        apb(1'b1, 12'h038, 32'h0000_0007);
        apb(1'b1, 12'h040, seed);
        for (r = 0; r < 3; r++)
        begin
            slow <= r[0];
            if (r == 2) apb(1'b1, 12'h038, 32'h0000_0006);
            apb(1'b1, 12'h000, 32'hffff_ffe0);
            apb(1'b1, 12'h004, 32'hffff_fff8);
            ev_on <= 1'b1;
            repeat (150) @(posedge pclk);
            ev_on <= 1'b0;
            repeat (4) @(posedge pclk);
            if (r == 0) apb(1'b1, 12'h030, 32'h0000_0004);
            for (i = 0; i < 14; i++) apb(1'b0, i * 4, 0);
            apb(1'b1, 12'h03c, 32'h0000_0001);
            for (i = 4; i < 8; i++) apb(1'b0, i * 4, 0);
            if (r == 1) apb(1'b1, 12'h034, 32'h0000_000f);
        end
        apb(1'b1, 12'h02c, 32'h0000_0080);
        ext_capture <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_capture <= 1'b0;
        for (i = 4; i < 8; i++) apb(1'b0, i * 4, 0);
        `CHK("irq count", nirq, xirq)
        `CHK("msi count", acks, xmsi)
        end_sim;
    end
endmodule
`default_nettype wire

// ===== logic/pcg_consts.vh
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
// Summary of operation
// - a carry out of the counter's top bit on increment is an overflow
// - each overflow sets that counter's bit in the overflow status array
// - counters keep counting after overflow; pending status never stalls them
// - interrupt needs both the counter's enable and the group-wide enable
// - interrupt and capture effects ignore the current overflow status bit
// - interrupt goes out as a wired edge, a message write, or both
// - message-signalled interrupts are offered alongside the wire
// - capture support flag reads 1; capture copies all counters at once
// - capture starts on software write of 1, enabled overflow, or external trigger
// - overflow-triggered capture stores the wrapped post-overflow counter value
// - after a capture write completes, later accesses see the new shadows
// - interrupt shows only after status, counter value and capture are visible
// - no coherent-access flag governs the message interrupt write
// - event ids are 16-bit numbers; 0x80 and above are implementation specific
// - event 0 counts clock cycles and is never stream filtered
// - event 1 counts once per client transaction or translation request
// - event 2 counts requests that miss in translation caches
// - event 2 counts requests needing a table walk or remote request
// - translation request events cover both ATS and non-ATS requests
// - group has 1 to 64 counters, each able to count any supported event

`define PCG_NCNT        4
`define PCG_IDXW        2
`define PCG_CW          32
`define PCG_AW          12
`define PCG_DW          32
`define PCG_EW          16

`define PCG_OFF_CNT     12'h000
`define PCG_OFF_SHD     12'h010
`define PCG_OFF_EVT     12'h020
`define PCG_OFF_OVSSET  12'h030
`define PCG_OFF_OVSCLR  12'h034
`define PCG_OFF_CTRL    12'h038
`define PCG_OFF_CAPR    12'h03c
`define PCG_OFF_MSIDATA 12'h040
`define PCG_OFF_CFGR    12'h044

`define PCG_EVT_ID_LSB      0
`define PCG_EVT_OVFCAP_BIT  30
`define PCG_EVT_IRQEN_BIT   31
`define PCG_CTRL_IRQEN_BIT  0
`define PCG_CTRL_MSIEN_BIT  1
`define PCG_CTRL_WIREEN_BIT 2
`define PCG_CAPR_BIT        0
`define PCG_CFGR_CAP_BIT    0
`define PCG_CFGR_MSI_BIT    1
`define PCG_CFGR_NCNT_LSB   8

`define PCG_EV_CYCLE    16'h0000
`define PCG_EV_TRANS    16'h0001
`define PCG_EV_TLBMISS  16'h0002
`define PCG_EV_ARCH_MAX 16'h007f

`define PCG_RST_CNT     32'h0000_0000
`define PCG_RST_EVT     32'h0000_0000
`define PCG_RST_CTRL    32'h0000_0004
`define PCG_RST_MSIDATA 32'h0000_0000
`define PCG_RST_OVS     4'h0
`endif

// ===== logic/pcg_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_counter (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 inc,
    input  wire                 wr_en,
    input  wire [`PCG_CW-1:0]   wr_data,
    output wire [`PCG_CW-1:0]   count,
    output wire [`PCG_CW-1:0]   nxt_count,
    output wire                 ovf
);
    reg  [`PCG_CW-1:0] count_ff;
    wire [`PCG_CW:0]   sum;

    // carry out of the top bit marks a wrap
    assign sum = {1'b0, count_ff} + {{`PCG_CW{1'b0}}, 1'b1};
    assign ovf = inc & ~wr_en & sum[`PCG_CW];
    // software write wins over an increment in the same cycle
    assign nxt_count = wr_en ? wr_data : (inc ? sum[`PCG_CW-1:0] : count_ff);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_ff <= `PCG_RST_CNT;
        else
            count_ff <= nxt_count;
    end

    assign count = count_ff;
endmodule
`default_nettype wire

// ===== logic/pcg_counter_group.v
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_counter_group (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire [`PCG_AW-1:0]   paddr,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [`PCG_DW-1:0]   pwdata,
    output wire [`PCG_DW-1:0]   prdata,
    output wire                 pready,
    output wire                 pslverr,
    input  wire                 evt_trans,
    input  wire                 evt_tlb_miss,
    input  wire                 ext_capture,
    output wire                 irq_wired,
    output wire                 msi_req,
    output wire [`PCG_DW-1:0]   msi_data,
    input  wire                 msi_ack
);
    localparam N  = `PCG_NCNT;
    localparam CW = `PCG_CW;
    localparam [5:0] NCNT_M1 = `PCG_NCNT - 1;

    // register block decode: word aligned, inside a block of N words
    function blk_hit;
        input [`PCG_AW-1:0] a;
        input [`PCG_AW-1:0] b;
        begin
            blk_hit = (a[`PCG_AW-1:`PCG_IDXW+2] == b[`PCG_AW-1:`PCG_IDXW+2])
                      && (a[1:0] == 2'b00);
        end
    endfunction

    // event selection for one counter
    function ev_hit;
        input [`PCG_EW-1:0] id;
        input               trans;
        input               miss;
        begin
            case (id)
                `PCG_EV_CYCLE:   ev_hit = 1'b1;
                `PCG_EV_TRANS:   ev_hit = trans;
                `PCG_EV_TLBMISS: ev_hit = miss;
                default:         ev_hit = 1'b0;
            endcase
        end
    endfunction

    reg  [`PCG_DW-1:0]  prdata_ff;
    reg                 pready_ff;
    reg                 pslverr_ff;
    reg  [`PCG_DW-1:0]  nxt_prdata;
    reg                 nxt_pslverr;
    reg  [`PCG_DW-1:0]  ctrl_ff;
    reg  [`PCG_DW-1:0]  msidata_ff;
    reg  [N-1:0]        ovs_ff;
    reg  [N-1:0]        nxt_ovs;
    reg                 irq_pend_ff;
    reg                 msi_pend_ff;
    reg                 irq_wired_ff;
    reg                 msi_req_ff;
    reg  [`PCG_DW-1:0]  msi_data_ff;
    reg                 ext_prev_ff;
    reg  [`PCG_DW-1:0]  evt_ff [0:N-1];
    reg  [CW-1:0]       shd_ff [0:N-1];

    wire                setup;
    wire                wr_fire;
    wire [`PCG_IDXW-1:0] idx;
    wire                ext_sync;
    wire                cap_sw;
    wire                cap_ovf;
    wire                cap_ext;
    wire                capture;
    wire                irq_qual;
    wire [N-1:0]        ovf_vec;
    wire [N-1:0]        inc_vec;
    wire [N-1:0]        irqen_vec;
    wire [N-1:0]        ovfcap_vec;
    wire [N*CW-1:0]     cnt_flat;
    wire [N*CW-1:0]     nxt_flat;
    wire [N-1:0]        ovs_set_w;
    wire [N-1:0]        ovs_clr_w;

    assign setup   = psel & ~penable;
    assign wr_fire = psel & penable & pready_ff & pwrite;
    assign idx     = paddr[`PCG_IDXW+1:2];

    // external capture trigger is asynchronous to pclk
    pcg_sync u_ext_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_capture),
        .dout    (ext_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < N; gi = gi + 1)
        begin : g_cnt
            localparam [`PCG_IDXW-1:0] IDX = gi;
            wire wr_cnt;
            wire wr_evt;

            assign wr_cnt = wr_fire & blk_hit(paddr, `PCG_OFF_CNT) & (idx == IDX);
            assign wr_evt = wr_fire & blk_hit(paddr, `PCG_OFF_EVT) & (idx == IDX);
            // any counter can take any supported event
            assign inc_vec[gi] = ev_hit(evt_ff[gi][`PCG_EVT_ID_LSB +: `PCG_EW],
                                        evt_trans, evt_tlb_miss);
            assign irqen_vec[gi]  = evt_ff[gi][`PCG_EVT_IRQEN_BIT];
            assign ovfcap_vec[gi] = evt_ff[gi][`PCG_EVT_OVFCAP_BIT];

            pcg_counter u_cnt (
                .pclk      (pclk),
                .presetn   (presetn),
                .inc       (inc_vec[gi]),
                .wr_en     (wr_cnt),
                .wr_data   (pwdata),
                .count     (cnt_flat[gi*CW +: CW]),
                .nxt_count (nxt_flat[gi*CW +: CW]),
                .ovf       (ovf_vec[gi])
            );

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    evt_ff[gi] <= `PCG_RST_EVT;
                else if (wr_evt)
                    evt_ff[gi] <= pwdata;
            end

            // all shadows load in the same edge from the next counter values
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    shd_ff[gi] <= `PCG_RST_CNT;
                else if (capture)
                    shd_ff[gi] <= nxt_flat[gi*CW +: CW];
            end
        end
    endgenerate

    // capture causes
    assign cap_sw  = wr_fire & (paddr == `PCG_OFF_CAPR) & pwdata[`PCG_CAPR_BIT];
    assign cap_ovf = |(ovf_vec & ovfcap_vec);
    assign cap_ext = ext_sync & ~ext_prev_ff;
    assign capture = cap_sw | cap_ovf | cap_ext;

    // interrupt qualification ignores the status bits
    assign irq_qual = ctrl_ff[`PCG_CTRL_IRQEN_BIT] & |(ovf_vec & irqen_vec);

    // overflow status set and clear views
    assign ovs_set_w = (wr_fire & (paddr == `PCG_OFF_OVSSET)) ? pwdata[N-1:0] : {N{1'b0}};
    assign ovs_clr_w = (wr_fire & (paddr == `PCG_OFF_OVSCLR)) ? pwdata[N-1:0] : {N{1'b0}};

    always @*
    begin
        // hardware set wins over a clear in the same cycle
        nxt_ovs = (ovs_ff & ~ovs_clr_w) | ovs_set_w | ovf_vec;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovs_ff <= `PCG_RST_OVS;
        else
            ovs_ff <= nxt_ovs;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff    <= `PCG_RST_CTRL;
            msidata_ff <= `PCG_RST_MSIDATA;
        end
        else if (wr_fire)
        begin
            if (paddr == `PCG_OFF_CTRL)
                ctrl_ff <= pwdata;
            if (paddr == `PCG_OFF_MSIDATA)
                msidata_ff <= pwdata;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_prev_ff <= 1'b0;
        else
            ext_prev_ff <= ext_sync;
    end

    // interrupt delivery: status, counters and shadows update at the overflow
    // edge; the pend stage holds the interrupt back one more edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pend_ff  <= 1'b0;
            msi_pend_ff  <= 1'b0;
            irq_wired_ff <= 1'b0;
        end
        else
        begin
            irq_pend_ff  <= irq_qual & ctrl_ff[`PCG_CTRL_WIREEN_BIT];
            msi_pend_ff  <= irq_qual & ctrl_ff[`PCG_CTRL_MSIEN_BIT];
            irq_wired_ff <= irq_pend_ff;
        end
    end

    // message write request held until acknowledged; plain write, no coherency
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msi_req_ff  <= 1'b0;
            msi_data_ff <= `PCG_RST_MSIDATA;
        end
        else if (msi_pend_ff)
        begin
            msi_req_ff  <= 1'b1;
            msi_data_ff <= msidata_ff;
        end
        else if (msi_ack)
            msi_req_ff <= 1'b0;
    end

    // read mux, sampled in the setup cycle
    always @*
    begin
        nxt_prdata  = {`PCG_DW{1'b0}};
        nxt_pslverr = 1'b0;
        if (blk_hit(paddr, `PCG_OFF_CNT))
            nxt_prdata = cnt_flat[idx*CW +: CW];
        else if (blk_hit(paddr, `PCG_OFF_SHD))
            nxt_prdata = shd_ff[idx];
        else if (blk_hit(paddr, `PCG_OFF_EVT))
            nxt_prdata = evt_ff[idx];
        else
        begin
            case (paddr)
                `PCG_OFF_OVSSET,
                `PCG_OFF_OVSCLR:  nxt_prdata[N-1:0] = ovs_ff;
                `PCG_OFF_CTRL:    nxt_prdata = ctrl_ff;
                `PCG_OFF_CAPR:    nxt_prdata = {`PCG_DW{1'b0}};
                `PCG_OFF_MSIDATA: nxt_prdata = msidata_ff;
                `PCG_OFF_CFGR:
                begin
                    nxt_prdata[`PCG_CFGR_CAP_BIT] = 1'b1;
                    nxt_prdata[`PCG_CFGR_MSI_BIT] = 1'b1;
                    nxt_prdata[`PCG_CFGR_NCNT_LSB +: 6] = NCNT_M1;
                end
                default:          nxt_pslverr = 1'b1;
            endcase
        end
    end

    // one wait-free access phase per transfer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= {`PCG_DW{1'b0}};
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= setup;
            if (setup)
            begin
                prdata_ff  <= pwrite ? {`PCG_DW{1'b0}} : nxt_prdata;
                pslverr_ff <= nxt_pslverr;
            end
            else
            begin
                prdata_ff  <= {`PCG_DW{1'b0}};
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign irq_wired = irq_wired_ff;
    assign msi_req   = msi_req_ff;
    assign msi_data  = msi_data_ff;
endmodule
`default_nettype wire

// ===== logic/pcg_sync.v
`timescale 1ns/1ps
`default_nettype none
module pcg_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire
